// [logic/pmsio_pkg.sv]
package pmsio_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] SUPV_CFG_ADDR  = 8'h13;
  localparam logic [7:0] RSTSW_CFG_ADDR = 8'h14;
  localparam logic [7:0] SUPV_CFG_RST   = 8'h4c;
  localparam logic [7:0] RSTSW_CFG_RST  = 8'hc0;
  localparam logic [7:0] RSTSW_WR_MASK  = 8'hcf;
  localparam logic [7:0] ENABLE_RST     = 8'h00;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int HOLD_TIME_BIT   = 7;
  localparam int BUF_TYPE_BIT    = 6;
  localparam int PAIRING_BIT     = 5;
  localparam int PG_DLY_LSB      = 3;
  localparam int TIGHT_BIT       = 2;
  localparam int UVLO_LSB        = 0;
  localparam int WARM_RST_BIT    = 7;
  localparam int UVLO_HYS_BIT    = 6;
  localparam int SW3_LIM_LSB     = 2;
  localparam int SW2_LIM_LSB     = 0;
  localparam int EN_PIN3_BIT     = 6;
  localparam int EN_PIN2_BIT     = 5;
  localparam int EN_PIN1_BIT     = 4;

  // ----------------------------------------
  // Power-good delay times
  // ----------------------------------------
  localparam int CLK_MHZ         = 125;
  localparam int PG_DLY0_MS      = 10;
  localparam int PG_DLY1_MS      = 20;
  localparam int PG_DLY2_MS      = 50;
  localparam int PG_DLY3_MS      = 150;
  localparam int PG_DLY0_CYC     = PG_DLY0_MS * 1000 * CLK_MHZ;
  localparam int PG_DLY1_CYC     = PG_DLY1_MS * 1000 * CLK_MHZ;
  localparam int PG_DLY2_CYC     = PG_DLY2_MS * 1000 * CLK_MHZ;
  localparam int PG_DLY3_CYC     = PG_DLY3_MS * 1000 * CLK_MHZ;
  localparam int PG_CNT_W        = 25;

  typedef struct packed {
    logic       hold_long;
    logic       second_output_buffer_type;
    logic       pin_pairing_sel;
    logic [1:0] power_good_delay_sel;
    logic       supervisor_tight_sel;
    logic [1:0] uvlo_sel;
  } pmsio_supv_t;

  typedef struct packed {
    logic       warm_reset_pin_mode;
    logic       undervoltage_lockout_hysteresis;
    logic [1:0] rsvd;
    logic [1:0] switch_three_limit_sel;
    logic [1:0] switch_two_limit_sel;
  } pmsio_rstsw_t;

  typedef enum logic [1:0] {
    PG_LOW   = 2'b00,
    PG_WAIT  = 2'b01,
    PG_HIGH  = 2'b10
  } pmsio_pg_t;

endpackage : pmsio_pkg

// [logic/pmsio_regs.sv]
`timescale 1ns/10ps
// Operation
// (RULE1) Supervisor register at 0x13 resets to 0x4C.
// (RULE2) Reset-pin and switch-limit register at 0x14 resets to 0xC0.
// (RULE3) Both registers need the password unlock before writes take effect.
// (RULE4) Bit 7 of 0x13 selects button hold 8 s or 15 s.
// (RULE5) Second output open-drain when 0, push-pull when 1.
// (RULE6) Pairing 1 makes first pin an input driving second output.
// (RULE7) While pairing is 1, software levels of pins one and two ignored.
// (RULE8) Power-good delay code 0..3 gives 10, 20, 50, 150 ms.
// (RULE9) Delay only before power-good rises; falling is immediate.
// (RULE10) Strictness bit picks tight limits and overvoltage monitoring.
// (RULE11) Warm-reset mode makes third pin a converter warm-reset input.
// (RULE12) In warm-reset mode the third pin level bit has no function.
// (RULE13) Bits 3:2 of 0x14 select switch three current limit.
// (RULE14) Bits 1:0 of 0x14 select switch two current limit.
// (RULE15) Reserved bits 5:4 of 0x14 read zero, writes ignored.
// (RULE16) Writes without a valid unlock leave stored value unchanged.
module pmsio_regs
  import pmsio_pkg::*;
(
  input  wire logic       SYS_CLK,
  input  wire logic       NRST,
  input  wire logic       WR_EN,
  input  wire logic [7:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       UNLOCKED,
  input  wire logic [7:0] ENABLE_REG,
  input  wire logic       RAILS_OK,
  input  wire logic       FIRST_PIN_IN,
  input  wire logic       THIRD_PIN_IN,
  output logic      [7:0] RDATA,
  output logic            HOLD_LONG,
  output logic            FIRST_PIN_OE,
  output logic            SECOND_OUT_O,
  output logic            SECOND_OUT_OE,
  output logic            THIRD_PIN_OE,
  output logic            WARM_RESET,
  output logic            OV_MON_EN,
  output logic            TIGHT_LIMITS,
  output logic      [1:0] UVLO_SEL,
  output logic            UVLO_HYS,
  output logic      [1:0] SW3_LIMIT,
  output logic      [1:0] SW2_LIMIT,
  output logic            POWER_GOOD
);

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  pmsio_supv_t  supv_r,  supv_nxt;
  pmsio_rstsw_t rstsw_r, rstsw_nxt;
  logic [7:0]   rdata_nxt;

  always_comb begin
    supv_nxt  = supv_r;
    rstsw_nxt = rstsw_r;
    if (WR_EN && UNLOCKED && ADDR == SUPV_CFG_ADDR) begin   // [RULE3] [RULE16]
      supv_nxt = pmsio_supv_t'(WDATA);
    end
    if (WR_EN && UNLOCKED && ADDR == RSTSW_CFG_ADDR) begin  // [RULE3] [RULE16]
      rstsw_nxt = pmsio_rstsw_t'(WDATA & RSTSW_WR_MASK);   // [RULE15]
    end
    case (ADDR)
      SUPV_CFG_ADDR:  rdata_nxt = supv_nxt;
      RSTSW_CFG_ADDR: rdata_nxt = rstsw_nxt;
      default:        rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      supv_r  <= pmsio_supv_t'(SUPV_CFG_RST);                // [RULE1]
      rstsw_r <= pmsio_rstsw_t'(RSTSW_CFG_RST);              // [RULE2]
      RDATA   <= 8'h00;
    end else begin
      supv_r  <= supv_nxt;
      rstsw_r <= rstsw_nxt;
      RDATA   <= rdata_nxt;
    end
  end

  // ----------------------------------------
  // Pin steering and config outputs
  // ----------------------------------------
  logic pair, first_oe_nxt, sec_o_nxt, sec_oe_nxt, third_oe_nxt, warm_nxt, sec_lvl;

  always_comb begin
    pair = supv_r.pin_pairing_sel;
    // Enable-register level bits: 0 drives low, 1 releases, or drives high on a push-pull second output
    sec_lvl      = pair ? FIRST_PIN_IN : ENABLE_REG[EN_PIN2_BIT];            // [RULE6] [RULE7]
    first_oe_nxt = pair ? 1'b0 : ~ENABLE_REG[EN_PIN1_BIT];                   // [RULE6] [RULE7]
    if (supv_r.second_output_buffer_type) begin                              // [RULE5]
      sec_o_nxt  = sec_lvl;
      sec_oe_nxt = 1'b1;
    end else begin
      sec_o_nxt  = 1'b0;
      sec_oe_nxt = ~sec_lvl;
    end
    third_oe_nxt = rstsw_r.warm_reset_pin_mode ? 1'b0 : ~ENABLE_REG[EN_PIN3_BIT]; // [RULE11] [RULE12]
    warm_nxt     = rstsw_r.warm_reset_pin_mode & ~THIRD_PIN_IN;             // [RULE11]
  end

  // ----------------------------------------
  // Power-good qualifier
  // ----------------------------------------
  pmsio_pg_t           pg_r, pg_nxt;
  logic [PG_CNT_W-1:0] cnt_r, cnt_nxt, dly_cyc;
  logic                pg_out_nxt;

  always_comb begin
    case (supv_r.power_good_delay_sel)                                      // [RULE8]
      2'd0:    dly_cyc = PG_CNT_W'(PG_DLY0_CYC);
      2'd1:    dly_cyc = PG_CNT_W'(PG_DLY1_CYC);
      2'd2:    dly_cyc = PG_CNT_W'(PG_DLY2_CYC);
      default: dly_cyc = PG_CNT_W'(PG_DLY3_CYC);
    endcase
    pg_nxt  = pg_r;
    cnt_nxt = cnt_r;
    case (pg_r)
      PG_LOW: begin
        cnt_nxt = '0;
        if (RAILS_OK) pg_nxt = PG_WAIT;
      end
      PG_WAIT: begin
        cnt_nxt = cnt_r + PG_CNT_W'(1);
        if (!RAILS_OK) pg_nxt = PG_LOW;
        else if (cnt_r + PG_CNT_W'(1) >= dly_cyc) pg_nxt = PG_HIGH;          // [RULE9]
      end
      PG_HIGH: begin
        if (!RAILS_OK) pg_nxt = PG_LOW;                                     // [RULE9]
      end
      default: pg_nxt = PG_LOW;
    endcase
    // Drop without delay: fault seen the same cycle it is sampled
    pg_out_nxt = (pg_nxt == PG_HIGH) && RAILS_OK;                           // [RULE9]
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      pg_r          <= PG_LOW;
      cnt_r         <= '0;
      POWER_GOOD    <= 1'b0;
      HOLD_LONG     <= 1'b0;
      FIRST_PIN_OE  <= 1'b0;
      SECOND_OUT_O  <= 1'b0;
      SECOND_OUT_OE <= 1'b0;
      THIRD_PIN_OE  <= 1'b0;
      WARM_RESET    <= 1'b0;
      OV_MON_EN     <= 1'b0;
      TIGHT_LIMITS  <= 1'b0;
      UVLO_SEL      <= 2'h0;
      UVLO_HYS      <= 1'b0;
      SW3_LIMIT     <= 2'h0;
      SW2_LIMIT     <= 2'h0;
    end else begin
      pg_r          <= pg_nxt;
      cnt_r         <= cnt_nxt;
      POWER_GOOD    <= pg_out_nxt;
      HOLD_LONG     <= supv_r.hold_long;                                    // [RULE4]
      FIRST_PIN_OE  <= first_oe_nxt;
      SECOND_OUT_O  <= sec_o_nxt;
      SECOND_OUT_OE <= sec_oe_nxt;
      THIRD_PIN_OE  <= third_oe_nxt;
      WARM_RESET    <= warm_nxt;
      OV_MON_EN     <= supv_r.supervisor_tight_sel;                         // [RULE10]
      TIGHT_LIMITS  <= supv_r.supervisor_tight_sel;                         // [RULE10]
      UVLO_SEL      <= supv_r.uvlo_sel;
      UVLO_HYS      <= rstsw_r.undervoltage_lockout_hysteresis;
      SW3_LIMIT     <= rstsw_r.switch_three_limit_sel;                      // [RULE13]
      SW2_LIMIT     <= rstsw_r.switch_two_limit_sel;                        // [RULE14]
    end
  end

endmodule : pmsio_regs

// [tb/pmsio_properties.sv]
`timescale 1ns/10ps
module pmsio_properties
  import pmsio_pkg::*;
(
  input wire logic       SYS_CLK,
  input wire logic       NRST,
  input wire logic       WR_EN,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic       UNLOCKED,
  input wire logic       RAILS_OK,
  input wire logic [7:0] RDATA,
  input wire logic       HOLD_LONG,
  input wire logic       THIRD_PIN_OE,
  input wire logic       WARM_RESET,
  input wire logic       OV_MON_EN,
  input wire logic       TIGHT_LIMITS,
  input wire logic [1:0] UVLO_SEL,
  input wire logic       UVLO_HYS,
  input wire logic [1:0] SW3_LIMIT,
  input wire logic [1:0] SW2_LIMIT,
  input wire logic       POWER_GOOD
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);
  // --------------------------------
  // Accepted writes
  // --------------------------------
  logic wr13;
  logic wr14;
  assign wr13 = WR_EN && UNLOCKED && ADDR == SUPV_CFG_ADDR;
  assign wr14 = WR_EN && UNLOCKED && ADDR == RSTSW_CFG_ADDR;
  a_wr_rdata: assert property (wr13 |=> RDATA == $past(WDATA))
    else $error("read data not updated by write");
  a_rsvd_mask: assert property (wr14 |=> RDATA == ($past(WDATA) & 8'hcf))
    else $error("reserved bits not zero");
  a_locked_keep: assert property (WR_EN && !UNLOCKED && $stable(ADDR) |=> $stable(RDATA))
    else $error("locked write changed register");
  a_supv_fields: assert property (wr13 |=> ##1 (HOLD_LONG == $past(WDATA[7], 2)
    && TIGHT_LIMITS == $past(WDATA[2], 2) && UVLO_SEL == $past(WDATA[1:0], 2)))
    else $error("supervisor fields wrong");
  a_limit_fields: assert property (wr14 |=> ##1 (SW3_LIMIT == $past(WDATA[3:2], 2)
    && SW2_LIMIT == $past(WDATA[1:0], 2) && UVLO_HYS == $past(WDATA[6], 2)))
    else $error("limit fields wrong");
  a_supervisor_tight_sel_ov: assert property (OV_MON_EN == TIGHT_LIMITS)
    else $error("overvoltage enable differs");
  a_pg_fall: assert property (!RAILS_OK |=> !POWER_GOOD)
    else $error("power good fall delayed");
  a_pg_delay: assert property ($rose(RAILS_OK) |=> !POWER_GOOD [*8])
    else $error("power good rose early");
  a_warm_input: assert property (WARM_RESET |-> !THIRD_PIN_OE)
    else $error("third pin driven in warm mode");
  c_wr13: cover property (wr13);
  c_locked: cover property (WR_EN && !UNLOCKED);
  c_rails: cover property ($rose(RAILS_OK));
endmodule : pmsio_properties

bind pmsio_regs pmsio_properties u_props (.SYS_CLK, .NRST, .WR_EN, .ADDR, .WDATA, .UNLOCKED,
  .RAILS_OK, .RDATA, .HOLD_LONG, .THIRD_PIN_OE, .WARM_RESET, .OV_MON_EN, .TIGHT_LIMITS,
  .UVLO_SEL, .UVLO_HYS, .SW3_LIMIT, .SW2_LIMIT, .POWER_GOOD);

// [tb/tb_pmsio_regs.sv]
`timescale 1ns/10ps
module tb_pmsio_regs;
  logic       SYS_CLK = 0, NRST = 0, WR_EN = 0, UNLOCKED = 0, RAILS_OK = 0;
  logic       FIRST_PIN_IN = 0, THIRD_PIN_IN = 0;
  logic [7:0] ADDR = 8'h13, WDATA = 8'h00, ENABLE_REG = 8'h00, RDATA;
  logic       HOLD_LONG, FIRST_PIN_OE, SECOND_OUT_O, SECOND_OUT_OE, THIRD_PIN_OE;
  logic       WARM_RESET, OV_MON_EN, TIGHT_LIMITS, UVLO_HYS, POWER_GOOD;
  logic [1:0] UVLO_SEL, SW3_LIMIT, SW2_LIMIT;
  int         failures = 0, cmp_count = 0;
  pmsio_regs u_dut (.SYS_CLK, .NRST, .WR_EN, .ADDR, .WDATA, .UNLOCKED, .ENABLE_REG, .RAILS_OK,
    .FIRST_PIN_IN, .THIRD_PIN_IN, .RDATA, .HOLD_LONG, .FIRST_PIN_OE, .SECOND_OUT_O,
    .SECOND_OUT_OE, .THIRD_PIN_OE, .WARM_RESET, .OV_MON_EN, .TIGHT_LIMITS, .UVLO_SEL,
    .UVLO_HYS, .SW3_LIMIT, .SW2_LIMIT, .POWER_GOOD);
  always #4 SYS_CLK = ~SYS_CLK;
  // --------------------------------
  // Access tasks
  // --------------------------------
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("Error %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [7:0] d, input logic u);
    @(negedge SYS_CLK);
    ADDR = a;
    WDATA = d;
    UNLOCKED = u;
    WR_EN = 1'b1;
    @(negedge SYS_CLK);
    WR_EN = 1'b0;
    UNLOCKED = 1'b0;
  endtask : wr
  // Two edges: read data lags the address by one cycle
  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge SYS_CLK);
    ADDR = a;
    repeat (2) @(negedge SYS_CLK);
    chk(RDATA, exp);
  endtask : rd
  task finish_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test
  // --------------------------------
  // Tests
  // --------------------------------
  initial begin
    repeat (4) @(negedge SYS_CLK);
    NRST = 1'b1;
    rd(8'h13, 8'h4c);
    rd(8'h14, 8'hc0);
    chk(HOLD_LONG, 8'h00);
    chk(TIGHT_LIMITS, 8'h01);
    wr(8'h13, 8'hff, 1'b0);
    rd(8'h13, 8'h4c);
    wr(8'h14, 8'h00, 1'b0);
    rd(8'h14, 8'hc0);
    for (int i = 0; i < 4; i++) begin
      wr(8'h14, {4'h7, i[1:0], ~i[1:0]}, 1'b1);
      rd(8'h14, {4'h4, i[1:0], ~i[1:0]});
      chk(SW3_LIMIT, i[1:0]);
      chk(SW2_LIMIT, {~i[1:0]});
      chk(UVLO_HYS, 8'h01);
      wr(8'h13, {i[0], 2'b00, i[1:0], ~i[0], 2'b00}, 1'b1);
      rd(8'h13, {i[0], 2'b00, i[1:0], ~i[0], 2'b00});
      chk(HOLD_LONG, i[0]);
      chk(OV_MON_EN, {~i[0]});
    end
    ENABLE_REG = 8'h70;
    repeat (3) @(negedge SYS_CLK);
    chk(SECOND_OUT_OE, 8'h00);
    ENABLE_REG = 8'h00;
    repeat (3) @(negedge SYS_CLK);
    chk(FIRST_PIN_OE, 8'h01);
    chk(THIRD_PIN_OE, 8'h01);
    FIRST_PIN_IN = 1'b1;
    wr(8'h13, 8'h60, 1'b1);
    wr(8'h14, 8'h80, 1'b1);
    repeat (3) @(negedge SYS_CLK);
    chk(FIRST_PIN_OE, 8'h00);
    chk(SECOND_OUT_O, 8'h01);
    chk(SECOND_OUT_OE, 8'h01);
    chk(WARM_RESET, 8'h01);
    chk(THIRD_PIN_OE, 8'h00);
    RAILS_OK = 1'b1;
    repeat (20) @(negedge SYS_CLK);
    chk(POWER_GOOD, 8'h00);
    RAILS_OK = 1'b0;
    repeat (2) @(negedge SYS_CLK);
    finish_test();
  end
  // Whole sequence is about a hundred cycles
  initial begin
    #100us;
    failures++;
    finish_test();
  end
endmodule : tb_pmsio_regs
